/* pgc_pkg.sv */
// Package for the peripheral clock gate controller: register map and types.
package pgc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          PGC_ADDR_W        = 4;
    localparam logic [3:0]  PGC_GATE_ONE_ADDR = 4'h0;
    localparam logic [3:0]  PGC_PRESENT_ADDR  = 4'h4;
    localparam logic [3:0]  PGC_ACTIVE_ADDR   = 4'h8;
    localparam logic [15:0] PGC_GATE_RESET    = 16'h0000;
    localparam logic [15:0] PGC_GATE_IMPL     = 16'hf9ff;
    localparam logic [15:0] PGC_UNMAPPED_DATA = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PGC_TIMER5_BIT      = 15;
    localparam int PGC_TIMER1_BIT      = 11;
    localparam int PGC_CODEC_BIT       = 8;
    localparam int PGC_TWO_WIRE_BIT    = 7;
    localparam int PGC_CONVERTER_BIT   = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int PGC_INSTR_DELAY_CYC = 1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PGC_ADDR_W-1:0] addr;
        logic [15:0]           wdata;
        logic                  wr;
        logic                  rd;
    } pgc_bus_req_type;

    typedef enum logic [1:0] {
        PGC_ST_RUN  = 2'b00,
        PGC_ST_WAIT = 2'b01
    } pgc_delay_state_type;

endpackage

/* pgc_delay.sv */
// One-instruction-cycle delay stage between gate bits and peripheral enables.
`timescale 1ns/1ps
`default_nettype none
module pgc_delay
    import pgc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = PGC_INSTR_DELAY_CYC
)(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] din_i,
    output logic      [WIDTH-1:0] dout_o
);

    logic [WIDTH-1:0] stage_q [DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < DEPTH; i++)
                stage_q[i] <= '0;
        end
        else
        begin
            stage_q[0] <= din_i;
            for (int i = 1; i < DEPTH; i++)
                stage_q[i] <= stage_q[i-1];
        end
    end

    assign dout_o = stage_q[DEPTH-1];

endmodule
`default_nettype wire

/* pgc_top.sv */
// Peripheral clock gate controller: gate register, clock enables, access gates.
`timescale 1ns/1ps
`default_nettype none
module pgc_top
    import pgc_pkg::*;
#(
    parameter logic [15:0] PRESENT_MASK = PGC_GATE_IMPL,
    parameter int          NUM_AN       = 16
)(
    input  wire logic                  CLK_I,
    input  wire logic                  SYS_RST_I,
    input  wire logic [PGC_ADDR_W-1:0] ADDR_I,
    input  wire logic [15:0]           WDATA_I,
    input  wire logic                  WR_I,
    input  wire logic                  RD_I,
    output logic      [15:0]           RDATA_O,
    input  wire logic [15:0]           PERI_WR_I,
    input  wire logic [15:0]           PERI_RD_I,
    input  wire logic [NUM_AN-1:0]     ANALOG_PIN_CONFIG_BITS_I,
    output logic      [15:0]           CLK_EN_O,
    output logic      [15:0]           PERI_WR_O,
    output logic      [15:0]           PERI_RD_VALID_O,
    output logic      [NUM_AN-1:0]     ANALOG_INPUT_CHANNEL_SEL_O
);

    // ------------------------------------------------------------------
    // Software register
    // ------------------------------------------------------------------
    pgc_bus_req_type req;
    logic [15:0]     gate_q;
    logic [15:0]     active_dly;
    logic [15:0]     active_d;
    logic [15:0]     rdata_q;
    logic [15:0]     clk_en_q;
    logic [15:0]     wr_q;
    logic [15:0]     rd_valid_q;
    logic [NUM_AN-1:0] an_q;
    logic            conv_on;

    assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

    function automatic logic [15:0] rd_mux(input logic [PGC_ADDR_W-1:0] a,
                                           input logic [15:0] g,
                                           input logic [15:0] act);
        case (a)
            PGC_GATE_ONE_ADDR: rd_mux = g & PGC_GATE_IMPL;
            PGC_PRESENT_ADDR:  rd_mux = PRESENT_MASK & PGC_GATE_IMPL;
            PGC_ACTIVE_ADDR:   rd_mux = act;
            default:           rd_mux = PGC_UNMAPPED_DATA;
        endcase
    endfunction

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            gate_q <= PGC_GATE_RESET;
        else if (req.wr && req.addr == PGC_GATE_ONE_ADDR)
            gate_q <= req.wdata & PGC_GATE_IMPL;
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            rdata_q <= '0;
        else if (req.rd)
            rdata_q <= rd_mux(req.addr, gate_q, clk_en_q);
        else
            rdata_q <= '0;
    end

    // ------------------------------------------------------------------
    // Enable computation
    // ------------------------------------------------------------------
    // Present and ungated; unimplemented positions can never be active.
    assign active_d = ~gate_q & PRESENT_MASK & PGC_GATE_IMPL;

    // This stage plus the output register gives a two-cycle lag behind the gate register.
    pgc_delay #(
        .WIDTH (16),
        .DEPTH (PGC_INSTR_DELAY_CYC)
    ) u_delay (
        .clk_i  (CLK_I),
        .rst_i  (SYS_RST_I),
        .din_i  (active_d),
        .dout_o (active_dly)
    );

    // ------------------------------------------------------------------
    // Outputs to the gated peripherals
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            clk_en_q <= '0;
        else
            clk_en_q <= active_dly;
    end

    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
        begin
            wr_q       <= '0;
            rd_valid_q <= '0;
        end
        else
        begin
            wr_q       <= PERI_WR_I & active_dly;
            rd_valid_q <= PERI_RD_I & active_dly;
        end
    end

    assign conv_on = active_dly[PGC_CONVERTER_BIT];

    // A clear selection bit means the pin stays digital.
    always_ff @(posedge CLK_I)
    begin
        if (SYS_RST_I)
            an_q <= '0;
        else if (!conv_on)
            an_q <= '0;
        else
            an_q <= ANALOG_PIN_CONFIG_BITS_I;
    end

    assign RDATA_O                    = rdata_q;
    assign CLK_EN_O                   = clk_en_q;
    assign PERI_WR_O                  = wr_q;
    assign PERI_RD_VALID_O            = rd_valid_q;
    assign ANALOG_INPUT_CHANNEL_SEL_O = an_q;

endmodule
`default_nettype wire

/* pgc_chk.sv */
// Checker for the peripheral clock gate controller ports.
`timescale 1ns/1ps
`default_nettype none
module pgc_chk
    import pgc_pkg::*;
#(
    parameter logic [15:0] PRESENT_MASK = PGC_GATE_IMPL,
    parameter int          NUM_AN       = 16
)(
    input wire logic                  CLK_I,
    input wire logic                  SYS_RST_I,
    input wire logic [PGC_ADDR_W-1:0] ADDR_I,
    input wire logic [15:0]           WDATA_I,
    input wire logic                  WR_I,
    input wire logic                  RD_I,
    input wire logic [15:0]           RDATA_O,
    input wire logic [15:0]           PERI_WR_I,
    input wire logic [15:0]           PERI_RD_I,
    input wire logic [NUM_AN-1:0]     ANALOG_PIN_CONFIG_BITS_I,
    input wire logic [15:0]           CLK_EN_O,
    input wire logic [15:0]           PERI_WR_O,
    input wire logic [15:0]           PERI_RD_VALID_O,
    input wire logic [NUM_AN-1:0]     ANALOG_INPUT_CHANNEL_SEL_O
);
default clocking @(posedge CLK_I); endclocking
default disable iff (SYS_RST_I);
gate_delay_a: assert property (WR_I && ADDR_I == PGC_GATE_ONE_ADDR |-> ##3
    CLK_EN_O == (~$past(WDATA_I, 3) & PRESENT_MASK & PGC_GATE_IMPL))
    else $error("gate delay");
wr_mask_a: assert property (PERI_WR_O == ($past(PERI_WR_I) & CLK_EN_O))
    else $error("write mask");
rd_mask_a: assert property (PERI_RD_VALID_O == ($past(PERI_RD_I) & CLK_EN_O))
    else $error("read mask");
analog_off_a: assert property (ANALOG_INPUT_CHANNEL_SEL_O == (CLK_EN_O[0] ?
    $past(ANALOG_PIN_CONFIG_BITS_I) : '0)) else $error("analog pins");
reset_enable_a: assert property ($fell(SYS_RST_I) |-> ##2
    CLK_EN_O == PRESENT_MASK) else $error("reset enables");
rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read idle");
unimpl_zero_a: assert property (RD_I && ADDR_I == PGC_GATE_ONE_ADDR |=>
    (RDATA_O & ~PGC_GATE_IMPL) == 16'h0000) else $error("unimpl bits");
present_rd_a: assert property (RD_I && ADDR_I == PGC_PRESENT_ADDR |=>
    RDATA_O == (PRESENT_MASK & PGC_GATE_IMPL)) else $error("present read");
cover property (WR_I && WDATA_I == 16'hffff);
cover property (|PERI_WR_I && PERI_WR_O == 16'h0000);
cover property (CLK_EN_O[0] && |ANALOG_INPUT_CHANNEL_SEL_O);
endmodule
bind pgc_top pgc_chk #(.PRESENT_MASK(PRESENT_MASK), .NUM_AN(NUM_AN)) u_chk (.*);
`default_nettype wire

/* pgc_peri_model.sv */
// Gated peripheral registers: a write toggles the addressed register.
`timescale 1ns/1ps
`default_nettype none
module pgc_peri_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] wr_i,
    output logic      [15:0] regs_o
);
    always_ff @(posedge clk_i)
        regs_o <= rst_i ? 16'h0000 : regs_o ^ wr_i;
endmodule
`default_nettype wire

/* tb_top.sv */
// Testbench for the peripheral clock gate controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pgc_pkg::*;
    localparam logic [15:0] P = 16'hb9ff;
    logic clk, rst, wr, rd;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, pwr, prd, cfg, en, pwo, prv, sel, regs, d;
    int n_errors = 0, checks = 0, cyc = 0;
    pgc_top #(.PRESENT_MASK(P), .NUM_AN(16)) DUT (.CLK_I(clk),
        .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .PERI_WR_I(pwr), .PERI_RD_I(prd),
        .ANALOG_PIN_CONFIG_BITS_I(cfg), .CLK_EN_O(en), .PERI_WR_O(pwo),
        .PERI_RD_VALID_O(prv), .ANALOG_INPUT_CHANNEL_SEL_O(sel));
    pgc_peri_model u_peri (.clk_i(clk), .rst_i(rst), .wr_i(pwo),
        .regs_o(regs));
    always #4 clk = ~clk;
    task chk(input string n, input logic [15:0] s, e);
        checks++;
        if (s !== e) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, s); end
    endtask
    task wr16(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk) {addr, wdata, wr} <= {a, v, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask
    task rd16(input logic [3:0] a);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    task pulse(input logic [15:0] v, e);
        @(posedge clk) {pwr, prd} <= {v, v};
        @(posedge clk) {pwr, prd} <= 32'h0;
        #1 chk("read valid", prv, e);
        chk("write pass", pwo, e);
        repeat (2) @(posedge clk);
    endtask
    task t_reset;
        rd16(PGC_GATE_ONE_ADDR); chk("gate", d, 16'h0000);
        chk("enables", en, P);
        chk("analog on", sel, 16'h00ff);
        rd16(PGC_PRESENT_ADDR); chk("present", d, P);
        rd16(4'hc); chk("unmapped", d, PGC_UNMAPPED_DATA);
        $display("reset test done");
    endtask
    task t_gate;
        wr16(PGC_GATE_ONE_ADDR, 16'hffff);
        rd16(PGC_GATE_ONE_ADDR); chk("gate", d, 16'hf9ff);
        @(posedge clk) #1 chk("enables", en, 16'h0000);
        pulse(16'hffff, 16'h0000); chk("peri regs", regs, 16'h0000);
        $display("gate test done");
    endtask
    task t_ungate;
        wr16(PGC_GATE_ONE_ADDR, 16'h0001);
        repeat (2) @(posedge clk);
        #1 chk("enables", en, P & 16'hfffe);
        pulse(16'hffff, P & 16'hfffe); chk("peri regs", regs, P & 16'hfffe);
        rd16(PGC_ACTIVE_ADDR); chk("active", d, P & 16'hfffe);
        chk("analog", sel, 16'h0000);
        $display("ungate test done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000) begin n_errors++; end_of_test; end
    end
    initial
    begin
        {clk, rst, addr, wdata, wr, rd, pwr, prd, cfg} = {2'b01, 70'h0};
        cfg = 16'h00ff;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset; t_gate; t_ungate; end_of_test;
    end
endmodule
`default_nettype wire
